// *** common/gpibd_pkg.sv ***
// Constants and state types for the bus command decoder
package gpibd_pkg;
  // Multiline command codes, seven bits
  localparam logic [6:0] CMD_GTL = 7'h01;
  localparam logic [6:0] CMD_SDC = 7'h04;
  localparam logic [6:0] CMD_GET = 7'h08;
  localparam logic [6:0] CMD_LLO = 7'h11;
  localparam logic [6:0] CMD_DCL = 7'h14;
  localparam logic [6:0] CMD_SPE = 7'h18;
  localparam logic [6:0] CMD_SPD = 7'h19;
  localparam logic [6:0] CMD_UNL = 7'h3F;
  localparam logic [6:0] CMD_UNT = 7'h5F;
  // Command group held in bits 6:5
  localparam logic [1:0] GRP_LAG = 2'h1;
  localparam logic [1:0] GRP_TAG = 2'h2;
  localparam logic [1:0] GRP_SCG = 2'h3;
  localparam int GRP_HI = 6;
  localparam int GRP_LO = 5;
  localparam int ADDR_HI = 4;
  localparam int CMD_HI = 6;
  localparam int RQS_BIT = 6;
  // Synchronised pin bundle layout
  localparam int PIN_W = 15;
  localparam int PIN_DIO_HI = 7;
  localparam int PIN_ATN = 8;
  localparam int PIN_IFC = 9;
  localparam int PIN_REN = 10;
  localparam int PIN_DAV = 11;
  localparam int PIN_NRFD = 12;
  localparam int PIN_NDAC = 13;
  localparam int PIN_EOI = 14;
  localparam logic [PIN_W-1:0] PIN_IDLE = 15'h7FFF;
  // Source settling time before data valid
  localparam int CLK_NS = 20;
  localparam int SETTLE_NS = 2000;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] SETTLE_LOAD = CNT_W'(SETTLE_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  typedef enum logic [1:0] {AH_IDLE, AH_READY, AH_HOLD, AH_DONE} gpibd_ah_e;
  typedef enum logic [1:0] {SH_IDLE, SH_GET, SH_SETTLE, SH_XFER} gpibd_sh_e;
endpackage : gpibd_pkg

// *** common/gpibd_if.sv ***
// Carrier between the decoder and its source handshake
`timescale 1ns/10ps
interface gpibd_if;
  logic talk_act;
  logic tx_valid;
  logic [7:0] tx_data;
  logic tx_eoi;
  logic tx_take;
  logic nrfd_t;
  logic ndac_t;
  logic [7:0] dio_oe;
  logic dav_oe;
  logic eoi_oe;
  modport ctl (
    output talk_act, tx_valid, tx_data, tx_eoi, nrfd_t, ndac_t,
    input tx_take, dio_oe, dav_oe, eoi_oe
  );
  modport sh (
    input talk_act, tx_valid, tx_data, tx_eoi, nrfd_t, ndac_t,
    output tx_take, dio_oe, dav_oe, eoi_oe
  );
endinterface : gpibd_if

// *** rtl/gpibd_sync.sv ***
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module gpibd_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] IDLE = '1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_r;
  wire [W-1:0] agree = ~(s2_r ^ s3_r);
  wire [W-1:0] q_nxt = (s2_r & agree) | (q_r & ~agree);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1_r <= IDLE;
      s2_r <= IDLE;
      s3_r <= IDLE;
      q_r <= IDLE;
    end
    else
    begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r <= q_nxt;
    end
  end

  assign q = q_r;
endmodule : gpibd_sync

// *** rtl/gpibd_src.sv ***
// Source handshake: places bytes on the bus as talker
`timescale 1ns/10ps
module gpibd_src (
  input wire logic clk,
  input wire logic rst,
  gpibd_if.sh bus
);
  gpibd_pkg::gpibd_sh_e st_r;
  gpibd_pkg::gpibd_sh_e st_nxt;
  logic [gpibd_pkg::CNT_W-1:0] cnt_r;
  logic [7:0] dio_r;
  logic eoi_r;
  logic dav_r;
  wire in_get = (st_r == gpibd_pkg::SH_GET);
  wire take = in_get && bus.tx_valid && bus.talk_act;
  wire lines_ok = !bus.nrfd_t && bus.ndac_t;
  wire settled = (cnt_r == gpibd_pkg::CNT_ZERO);

  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      gpibd_pkg::SH_IDLE: st_nxt = gpibd_pkg::SH_GET;
      gpibd_pkg::SH_GET: if (take) st_nxt = gpibd_pkg::SH_SETTLE;
      // Data valid only once all acceptors are ready
      gpibd_pkg::SH_SETTLE: if (settled && lines_ok) st_nxt = gpibd_pkg::SH_XFER;
      gpibd_pkg::SH_XFER: if (!bus.ndac_t) st_nxt = gpibd_pkg::SH_GET;
      default: st_nxt = gpibd_pkg::SH_IDLE;
    endcase
    if (!bus.talk_act)
      st_nxt = gpibd_pkg::SH_IDLE;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_r <= gpibd_pkg::SH_IDLE;
      cnt_r <= gpibd_pkg::CNT_ZERO;
      dio_r <= 8'h00;
      eoi_r <= 1'b0;
      dav_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      if (take)
        cnt_r <= gpibd_pkg::SETTLE_LOAD;
      else if (!settled)
        cnt_r <= cnt_r - 1'b1;
      if (st_nxt == gpibd_pkg::SH_IDLE)
      begin
        dio_r <= 8'h00;
        eoi_r <= 1'b0;
      end
      else if (take)
      begin
        dio_r <= bus.tx_data;
        eoi_r <= bus.tx_eoi;
      end
      dav_r <= (st_nxt == gpibd_pkg::SH_XFER);
    end
  end

  assign bus.tx_take = take;
  assign bus.dio_oe = dio_r;
  assign bus.eoi_oe = eoi_r;
  assign bus.dav_oe = dav_r;

  property p_src_dav_ready;
    @(posedge clk) disable iff (rst)
    $rose(dav_r) |-> $past(bus.ndac_t) && !$past(bus.nrfd_t) &&
      $past(settled);
  endproperty
  a_src_dav_ready: assert property (p_src_dav_ready)
    else $error("data valid driven before acceptors ready");

  property p_src_quiet;
    @(posedge clk) disable iff (rst)
    !bus.talk_act |=> !dav_r && (dio_r == 8'h00);
  endproperty
  a_src_quiet: assert property (p_src_quiet)
    else $error("bus driven while not active talker");
endmodule : gpibd_src

// *** rtl/gpibd_top.sv ***
// Device-side decoder for bus interface commands
// Behaviour
// - Addressed commands act only while addressed listener
// - Selective clear restores defaults like device clear
// - Go-to-local while listener leaves remote mode
// - Group trigger while listener pulses trigger output
// - Own listen address makes device listener
// - Own talk address makes device talker
// - Secondary command group bytes are ignored
// - Unlisten drops listener addressing
// - Untalk drops talker addressing
// - Attention-false bytes go to parser when listening
// - Lockout, clear, poll enable/disable decoded universally
// - Talk when addressed or with talk_only set; listen address unaddresses
// - Listen only when addressed; talk address unaddresses
// - Full source and acceptor handshakes
// - Service request and status byte on poll
// - Remote, local and lockout states under control
// - Never drive attention, clear or enable lines
// - Bus lines only pulled low, else released
// - Interface clear idles talker and listener
// - Enable plus own listen address enters remote
`timescale 1ns/10ps
module gpibd_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] my_addr,
  input wire logic talk_only,
  input wire logic local_req,
  input wire logic [7:0] dio_n_in,
  output logic [7:0] dio_n_out,
  output logic [7:0] dio_n_oe,
  input wire logic atn_n_in,
  input wire logic ifc_n_in,
  input wire logic ren_n_in,
  input wire logic eoi_n_in,
  output logic eoi_n_out,
  output logic eoi_n_oe,
  input wire logic dav_n_in,
  output logic dav_n_out,
  output logic dav_n_oe,
  input wire logic nrfd_n_in,
  output logic nrfd_n_out,
  output logic nrfd_n_oe,
  input wire logic ndac_n_in,
  output logic ndac_n_out,
  output logic ndac_n_oe,
  output logic srq_n_out,
  output logic srq_n_oe,
  output logic [7:0] rx_data,
  output logic rx_eoi,
  output logic rx_valid,
  input wire logic rx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_eoi,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] status_byte,
  input wire logic rsv,
  output logic trigger,
  output logic dev_clear,
  output logic listener,
  output logic talker,
  output logic remote,
  output logic lockout,
  output logic spoll_mode
);
  logic [gpibd_pkg::PIN_W-1:0] pin_s;
  gpibd_pkg::gpibd_ah_e ah_r;
  gpibd_pkg::gpibd_ah_e ah_nxt;
  logic [7:0] cap_r;
  logic cap_eoi_r;
  logic cap_atn_r;
  logic lad_r;
  logic lad_nxt;
  logic tad_r;
  logic tad_nxt;
  logic spms_r;
  logic spms_nxt;
  logic rem_r;
  logic rem_nxt;
  logic llo_r;
  logic llo_nxt;
  logic trig_r;
  logic clr_r;
  logic poll_done_r;
  logic srq_oe_r;
  logic nrfd_oe_r;
  logic ndac_oe_r;

  gpibd_if sh_if ();

  // All bus inputs pass the three-stage filter
  gpibd_sync #(
    .W(gpibd_pkg::PIN_W),
    .IDLE(gpibd_pkg::PIN_IDLE)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .d({eoi_n_in, ndac_n_in, nrfd_n_in, dav_n_in, ren_n_in, ifc_n_in,
        atn_n_in, dio_n_in}),
    .q(pin_s)
  );

  gpibd_src u_src (
    .clk(clk),
    .rst(rst),
    .bus(sh_if.sh)
  );

  // Lines are low-true; convert to true-high levels
  wire atn_s = !pin_s[gpibd_pkg::PIN_ATN];
  wire ifc_s = !pin_s[gpibd_pkg::PIN_IFC];
  wire ren_s = !pin_s[gpibd_pkg::PIN_REN];
  wire dav_s = !pin_s[gpibd_pkg::PIN_DAV];
  wire eoi_s = !pin_s[gpibd_pkg::PIN_EOI];
  wire [7:0] dio_s = ~pin_s[gpibd_pkg::PIN_DIO_HI:0];

  // Command decode on the captured byte, bit 7 dropped
  wire [6:0] cmd = cap_r[gpibd_pkg::CMD_HI:0];
  wire [1:0] grp = cmd[gpibd_pkg::GRP_HI:gpibd_pkg::GRP_LO];
  wire addr_hit = (cmd[gpibd_pkg::ADDR_HI:0] == my_addr);
  wire cmd_go = (ah_r == gpibd_pkg::AH_HOLD) && cap_atn_r;
  wire is_unl = (cmd == gpibd_pkg::CMD_UNL);
  wire is_unt = (cmd == gpibd_pkg::CMD_UNT);
  wire is_mla = (grp == gpibd_pkg::GRP_LAG) && addr_hit && !is_unl;
  wire is_mta = (grp == gpibd_pkg::GRP_TAG) && addr_hit && !is_unt;
  wire is_ota = (grp == gpibd_pkg::GRP_TAG) && !addr_hit && !is_unt;
  // Secondary group matches none of the decodes below
  wire addressed_ok = cmd_go && lad_r;
  wire do_gtl = addressed_ok && (cmd == gpibd_pkg::CMD_GTL);
  wire do_sdc = addressed_ok && (cmd == gpibd_pkg::CMD_SDC);
  wire do_get = addressed_ok && (cmd == gpibd_pkg::CMD_GET);
  wire do_llo = cmd_go && (cmd == gpibd_pkg::CMD_LLO);
  wire do_dcl = cmd_go && (cmd == gpibd_pkg::CMD_DCL);
  wire do_spe = cmd_go && (cmd == gpibd_pkg::CMD_SPE);
  wire do_spd = cmd_go && (cmd == gpibd_pkg::CMD_SPD);
  wire do_clr = do_sdc || do_dcl;

  // Acceptor engaged on any command or as listener for data
  wire engaged = !ifc_s && (atn_s || lad_r);
  wire srq_pend = rsv && !poll_done_r;
  wire [7:0] stb = {status_byte[7], srq_pend, status_byte[5:0]};
  wire stb_sent = sh_if.tx_take && spms_r;

  always_comb
  begin
    ah_nxt = ah_r;
    case (ah_r)
      gpibd_pkg::AH_IDLE: ah_nxt = gpibd_pkg::AH_READY;
      gpibd_pkg::AH_READY: if (dav_s) ah_nxt = gpibd_pkg::AH_HOLD;
      gpibd_pkg::AH_HOLD:
        if (cap_atn_r || rx_ready) ah_nxt = gpibd_pkg::AH_DONE;
      gpibd_pkg::AH_DONE: if (!dav_s) ah_nxt = gpibd_pkg::AH_READY;
      default: ah_nxt = gpibd_pkg::AH_IDLE;
    endcase
    if (!engaged)
      ah_nxt = gpibd_pkg::AH_IDLE;
  end

  always_comb
  begin
    lad_nxt = lad_r;
    tad_nxt = tad_r;
    if (ifc_s)
    begin
      lad_nxt = 1'b0;
      tad_nxt = 1'b0;
    end
    else if (cmd_go)
    begin
      if (is_unl)
        lad_nxt = 1'b0;
      else if (is_mla)
      begin
        lad_nxt = 1'b1;
        tad_nxt = 1'b0;
      end
      if (is_unt || is_ota)
        tad_nxt = 1'b0;
      else if (is_mta)
      begin
        tad_nxt = 1'b1;
        lad_nxt = 1'b0;
      end
    end
  end

  always_comb
  begin
    spms_nxt = spms_r;
    if (ifc_s || do_spd || do_clr)
      spms_nxt = 1'b0;
    else if (do_spe)
      spms_nxt = 1'b1;
    rem_nxt = rem_r;
    llo_nxt = llo_r;
    if (!ren_s)
    begin
      rem_nxt = 1'b0;
      llo_nxt = 1'b0;
    end
    else
    begin
      if (do_llo)
        llo_nxt = 1'b1;
      if (do_gtl)
        rem_nxt = 1'b0;
      else if (cmd_go && is_mla)
        rem_nxt = 1'b1;
      else if (local_req && !llo_r)
        rem_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ah_r <= gpibd_pkg::AH_IDLE;
      cap_r <= 8'h00;
      cap_eoi_r <= 1'b0;
      cap_atn_r <= 1'b0;
      nrfd_oe_r <= 1'b0;
      ndac_oe_r <= 1'b0;
    end
    else
    begin
      ah_r <= ah_nxt;
      if ((ah_r == gpibd_pkg::AH_READY) && dav_s)
      begin
        cap_r <= dio_s;
        cap_eoi_r <= eoi_s;
        cap_atn_r <= atn_s;
      end
      nrfd_oe_r <= (ah_nxt == gpibd_pkg::AH_HOLD) ||
                   (ah_nxt == gpibd_pkg::AH_DONE);
      ndac_oe_r <= (ah_nxt == gpibd_pkg::AH_READY) ||
                   (ah_nxt == gpibd_pkg::AH_HOLD);
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lad_r <= 1'b0;
      tad_r <= 1'b0;
      spms_r <= 1'b0;
      rem_r <= 1'b0;
      llo_r <= 1'b0;
      trig_r <= 1'b0;
      clr_r <= 1'b0;
      poll_done_r <= 1'b0;
      srq_oe_r <= 1'b0;
    end
    else
    begin
      lad_r <= lad_nxt;
      tad_r <= tad_nxt;
      spms_r <= spms_nxt;
      rem_r <= rem_nxt;
      llo_r <= llo_nxt;
      trig_r <= do_get;
      clr_r <= do_clr;
      if (stb_sent && rsv)
        poll_done_r <= 1'b1;
      else if (!rsv)
        poll_done_r <= 1'b0;
      srq_oe_r <= srq_pend;
    end
  end

  // Talker feeds status byte while serial poll mode is on
  assign sh_if.talk_act = (tad_r || talk_only) && !atn_s && !ifc_s;
  assign sh_if.tx_valid = spms_r || tx_valid;
  assign sh_if.tx_data = spms_r ? stb : tx_data;
  assign sh_if.tx_eoi = !spms_r && tx_eoi;
  assign sh_if.nrfd_t = !pin_s[gpibd_pkg::PIN_NRFD];
  assign sh_if.ndac_t = !pin_s[gpibd_pkg::PIN_NDAC];
  assign tx_ready = sh_if.tx_take && !spms_r;

  // Open-drain: level always low, enable decides
  assign dio_n_out = 8'h00;
  assign dio_n_oe = sh_if.dio_oe;
  assign eoi_n_out = 1'b0;
  assign eoi_n_oe = sh_if.eoi_oe;
  assign dav_n_out = 1'b0;
  assign dav_n_oe = sh_if.dav_oe;
  assign nrfd_n_out = 1'b0;
  assign nrfd_n_oe = nrfd_oe_r;
  assign ndac_n_out = 1'b0;
  assign ndac_n_oe = ndac_oe_r;
  assign srq_n_out = 1'b0;
  assign srq_n_oe = srq_oe_r;

  assign rx_data = cap_r;
  assign rx_eoi = cap_eoi_r;
  assign rx_valid = (ah_r == gpibd_pkg::AH_HOLD) && !cap_atn_r;
  assign trigger = trig_r;
  assign dev_clear = clr_r;
  assign listener = lad_r;
  assign talker = tad_r;
  assign remote = rem_r;
  assign lockout = llo_r;
  assign spoll_mode = spms_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_cmd(logic [6:0] code);
    cmd_go && !ifc_s && (cmd == code);
  endsequence
  sequence s_byte_seen;
    (ah_r == gpibd_pkg::AH_READY) && dav_s && engaged;
  endsequence

  property p_addr_gate;
    s_cmd(gpibd_pkg::CMD_GET) ##0 !lad_r |=> !trigger;
  endproperty
  a_addr_gate: assert property (p_addr_gate)
    else $error("addressed command acted on while not listener");

  property p_sdc;
    s_cmd(gpibd_pkg::CMD_SDC) ##0 lad_r |=> dev_clear && !spoll_mode;
  endproperty
  a_sdc: assert property (p_sdc)
    else $error("selective clear not applied");

  property p_gtl;
    s_cmd(gpibd_pkg::CMD_GTL) ##0 lad_r |=> !remote;
  endproperty
  a_gtl: assert property (p_gtl)
    else $error("go to local did not leave remote");

  property p_get;
    s_cmd(gpibd_pkg::CMD_GET) ##0 lad_r |=> trigger ##1 !trigger;
  endproperty
  a_get: assert property (p_get)
    else $error("trigger not a single pulse");

  property p_mla;
    cmd_go && !ifc_s && is_mla |=> listener && !talker;
  endproperty
  a_mla: assert property (p_mla)
    else $error("own listen address not taken");

  property p_mta;
    cmd_go && !ifc_s && is_mta |=> talker && !listener;
  endproperty
  a_mta: assert property (p_mta)
    else $error("own talk address not taken");

  property p_scg;
    cmd_go && !ifc_s && (grp == gpibd_pkg::GRP_SCG)
      |=> $stable(listener) && $stable(talker) && $stable(spoll_mode);
  endproperty
  a_scg: assert property (p_scg)
    else $error("secondary byte changed state");

  property p_unl;
    s_cmd(gpibd_pkg::CMD_UNL) |=> !listener;
  endproperty
  a_unl: assert property (p_unl)
    else $error("unlisten ignored");

  property p_unt;
    s_cmd(gpibd_pkg::CMD_UNT) |=> !talker;
  endproperty
  a_unt: assert property (p_unt)
    else $error("untalk ignored");

  property p_rx_hold;
    rx_valid && !rx_ready |=> rx_valid && $stable(rx_data);
  endproperty
  a_rx_hold: assert property (p_rx_hold)
    else $error("received data lost before taken");

  property p_spe;
    s_cmd(gpibd_pkg::CMD_SPE) |=> spoll_mode;
  endproperty
  a_spe: assert property (p_spe)
    else $error("serial poll enable ignored");

  property p_accept;
    s_byte_seen |=> nrfd_n_oe && ndac_n_oe;
  endproperty
  a_accept: assert property (p_accept)
    else $error("acceptor did not hold byte");

  property p_ifc;
    ifc_s |=> !listener && !talker && !spoll_mode;
  endproperty
  a_ifc: assert property (p_ifc)
    else $error("interface clear not applied");

  property p_ren_off;
    !ren_s |=> !remote && !lockout;
  endproperty
  a_ren_off: assert property (p_ren_off)
    else $error("remote held without enable");
endmodule : gpibd_top

// *** dv/gpibd_ctl_model.sv ***
// Bus controller model: sends commands and data, accepts talker bytes
`timescale 1ns/10ps
module gpibd_ctl_model (
  input wire logic clk,
  input wire logic [7:0] dio_w,
  input wire logic dav_w,
  input wire logic nrfd_w,
  input wire logic ndac_w,
  output logic [7:0] dio_t,
  output logic atn_t,
  output logic ifc_t,
  output logic ren_t,
  output logic dav_t,
  output logic nrfd_t,
  output logic ndac_t,
  output logic hung
);
  localparam int LIM = 3000;
  initial
  begin
    dio_t = 8'h00;
    atn_t = 1'h0;
    ifc_t = 1'h0;
    ren_t = 1'h0;
    dav_t = 1'h0;
    nrfd_t = 1'h0;
    ndac_t = 1'h0;
    hung = 1'h0;
  end
  task automatic step();
    @(posedge clk);
    #1;
  endtask : step
  // Uniline controls, then let the filters settle
  task automatic uni(input logic ren, input logic ifc);
    ren_t = ren;
    ifc_t = ifc;
    repeat (8) step();
  endtask : uni
  task automatic set_atn(input logic a);
    if (atn_t !== a)
    begin
      atn_t = a;
      repeat (8) step();
    end
  endtask : set_atn
  // One byte as source; ATN held as given for the whole byte
  task automatic send(input logic atn, input logic [7:0] b);
    int n;
    set_atn(atn);
    dio_t = b;
    step();
    for (n = 0; n < LIM && !(nrfd_w && !ndac_w); n++) step();
    if (n == LIM) hung = 1'h1;
    dav_t = 1'h1;
    for (n = 0; n < LIM && !ndac_w; n++) step();
    if (n == LIM) hung = 1'h1;
    dav_t = 1'h0;
    dio_t = 8'h00;
  endtask : send
  // One byte as sole acceptor, ATN false
  task automatic recv(output logic [7:0] b);
    int n;
    set_atn(1'h0);
    ndac_t = 1'h1;
    nrfd_t = 1'h0;
    for (n = 0; n < LIM && dav_w; n++) step();
    if (n == LIM) hung = 1'h1;
    b = ~dio_w;
    nrfd_t = 1'h1;
    ndac_t = 1'h0;
    for (n = 0; n < LIM && !dav_w; n++) step();
    if (n == LIM) hung = 1'h1;
    nrfd_t = 1'h0;
  endtask : recv
endmodule : gpibd_ctl_model

// *** dv/gpibd_top_test.sv ***
// Testbench for the bus command decoder
`timescale 1ns/10ps
module gpibd_top_test;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic local_req = 1'h0;
  logic talk_only = 1'h0;
  logic tx_eoi = 1'h0;
  logic eoi_c = 1'h0;
  logic rx_ready = 1'h1;
  logic [7:0] tx_data = 8'h00;
  logic tx_valid = 1'h0;
  logic [7:0] status_byte = 8'h05;
  logic rsv = 1'h0;
  logic [7:0] dio_c, dio_n_out, dio_n_oe, rx_data, b, last_rx;
  logic atn_c, ifc_c, ren_c, dav_c, nrfd_c, ndac_c, hung;
  logic eoi_n_out, eoi_n_oe, dav_n_out, dav_n_oe, nrfd_n_out, nrfd_n_oe;
  logic ndac_n_out, ndac_n_oe, srq_n_out, srq_n_oe, rx_eoi, rx_valid;
  logic tx_ready, trigger, dev_clear, listener, talker, remote, lockout;
  logic spoll_mode;
  logic bad_drv = 1'h0;
  logic [7:0] n_trig = 8'h00;
  logic [7:0] n_clr = 8'h00;
  logic [7:0] n_rx = 8'h00;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  wire logic [7:0] dio_w = ~(dio_c | dio_n_oe);
  wire logic dav_w = ~(dav_c | dav_n_oe);
  wire logic nrfd_w = ~(nrfd_c | nrfd_n_oe);
  wire logic ndac_w = ~(ndac_c | ndac_n_oe);
  always #10 clk = ~clk;
  gpibd_top uut (.clk(clk), .rst(rst), .my_addr(5'h16),
    .talk_only(talk_only),
    .local_req(local_req), .dio_n_in(dio_w), .dio_n_out(dio_n_out),
    .dio_n_oe(dio_n_oe), .atn_n_in(~atn_c), .ifc_n_in(~ifc_c),
    .ren_n_in(~ren_c), .eoi_n_in(~(eoi_c | eoi_n_oe)),
    .eoi_n_out(eoi_n_out),
    .eoi_n_oe(eoi_n_oe), .dav_n_in(dav_w), .dav_n_out(dav_n_out),
    .dav_n_oe(dav_n_oe), .nrfd_n_in(nrfd_w), .nrfd_n_out(nrfd_n_out),
    .nrfd_n_oe(nrfd_n_oe), .ndac_n_in(ndac_w), .ndac_n_out(ndac_n_out),
    .ndac_n_oe(ndac_n_oe), .srq_n_out(srq_n_out), .srq_n_oe(srq_n_oe),
    .rx_data(rx_data), .rx_eoi(rx_eoi), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .tx_data(tx_data), .tx_eoi(tx_eoi),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .status_byte(status_byte),
    .rsv(rsv), .trigger(trigger), .dev_clear(dev_clear),
    .listener(listener), .talker(talker), .remote(remote),
    .lockout(lockout), .spoll_mode(spoll_mode));
  gpibd_ctl_model ctl (.clk(clk), .dio_w(dio_w), .dav_w(dav_w),
    .nrfd_w(nrfd_w), .ndac_w(ndac_w), .dio_t(dio_c), .atn_t(atn_c),
    .ifc_t(ifc_c), .ren_t(ren_c), .dav_t(dav_c), .nrfd_t(nrfd_c),
    .ndac_t(ndac_c), .hung(hung));
  always @(posedge clk)
  begin
    if (trigger === 1'h1) n_trig <= n_trig + 8'h01;
    if (dev_clear === 1'h1) n_clr <= n_clr + 8'h01;
    if (rx_valid === 1'h1 && rx_ready)
    begin
      last_rx <= rx_data;
      n_rx <= n_rx + 8'h01;
    end
    if ({dio_n_out, eoi_n_out, dav_n_out, nrfd_n_out, ndac_n_out,
         srq_n_out} !== 13'h0000) bad_drv <= 1'h1;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (n_mismatch == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict
  task automatic check(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic step();
    @(posedge clk);
    #1;
  endtask : step
  task automatic cmd(input logic [6:0] c);
    ctl.send(1'h1, {1'h0, c});
    repeat (2) step();
  endtask : cmd
  task automatic front_local();
    local_req = 1'h1;
    step();
    local_req = 1'h0;
    repeat (4) step();
  endtask : front_local
  // Hold the byte until the source takes it
  task automatic send_tx(input logic [7:0] d);
    int n;
    tx_data = d;
    tx_valid = 1'h1;
    for (n = 0; n < 500; n++)
    begin
      @(posedge clk);
      if (tx_ready === 1'h1) break;
    end
    #1;
    tx_valid = 1'h0;
  endtask : send_tx
  initial
  begin
    repeat (6) @(posedge clk);
    #1;
    rst = 1'h0;
    repeat (4) step();
    check("listener", listener, 8'h00);
    ctl.uni(1'h1, 1'h0);
    cmd(gpibd_pkg::CMD_GET);
    check("trigger", n_trig, 8'h00);
    cmd(gpibd_pkg::CMD_UNL);
    cmd(7'h36);
    check("listener", listener, 8'h01);
    check("remote", remote, 8'h01);
    front_local();
    check("remote", remote, 8'h00);
    cmd(7'h36);
    cmd(gpibd_pkg::CMD_GET);
    check("trigger", n_trig, 8'h01);
    ctl.send(1'h1, 8'h88);
    repeat (2) step();
    check("trigger", n_trig, 8'h02);
    cmd(gpibd_pkg::CMD_SDC);
    check("clear", n_clr, 8'h01);
    cmd(gpibd_pkg::CMD_GTL);
    check("remote", remote, 8'h00);
    cmd(7'h76);
    check("state", {listener, talker}, 8'h02);
    ctl.send(1'h0, 8'h52);
    repeat (2) step();
    check("rx", last_rx, 8'h52);
    check("rx count", n_rx, 8'h01);
    rx_ready = 1'h0;
    eoi_c = 1'h1;
    fork
      ctl.send(1'h0, 8'h53);
      begin
        repeat (30) step();
        check("rx valid", rx_valid, 8'h01);
        check("rx data", rx_data, 8'h53);
        check("rx eoi", rx_eoi, 8'h01);
        rx_ready = 1'h1;
      end
    join
    eoi_c = 1'h0;
    repeat (2) step();
    check("rx count", n_rx, 8'h02);
    cmd(7'h56);
    check("state", {listener, talker}, 8'h01);
    cmd(7'h36);
    check("state", {listener, talker}, 8'h02);
    cmd(7'h56);
    fork
      ctl.recv(b);
      send_tx(8'hA5);
    join
    check("tx", b, 8'hA5);
    rsv = 1'h1;
    repeat (4) step();
    check("srq", srq_n_oe, 8'h01);
    cmd(gpibd_pkg::CMD_SPE);
    check("spoll", spoll_mode, 8'h01);
    ctl.recv(b);
    check("status", b, 8'h45);
    repeat (4) step();
    check("srq", srq_n_oe, 8'h00);
    cmd(gpibd_pkg::CMD_SPD);
    check("spoll", spoll_mode, 8'h00);
    cmd(gpibd_pkg::CMD_UNT);
    check("talker", talker, 8'h00);
    cmd(gpibd_pkg::CMD_LLO);
    check("lockout", lockout, 8'h01);
    cmd(7'h36);
    front_local();
    check("remote", remote, 8'h01);
    cmd(gpibd_pkg::CMD_DCL);
    check("clear", n_clr, 8'h02);
    cmd(gpibd_pkg::CMD_UNL);
    check("listener", listener, 8'h00);
    cmd(7'h36);
    ctl.uni(1'h1, 1'h1);
    check("listener", listener, 8'h00);
    ctl.uni(1'h0, 1'h0);
    check("remote", {remote, lockout}, 8'h00);
    talk_only = 1'h1;
    tx_eoi = 1'h1;
    fork
      ctl.recv(b);
      send_tx(8'h3C);
    join
    check("talk only", b, 8'h3C);
    check("eoi", eoi_n_oe, 8'h01);
    talk_only = 1'h0;
    tx_eoi = 1'h0;
    check("hang", hung, 8'h00);
    check("drive", bad_drv, 8'h00);
    print_verdict();
  end
endmodule : gpibd_top_test
